// ==== src/tmhl_pkg.sv ====
// Constants, types and mode codes shared by the hardware-limit timer.
// Assumes a single 40 MHz clock and a classic Wishbone slave port.
//
// Summary of operation
// - Level limit modes hold count reset: low input for b00110, high for b00111.
// - Level limit modes ignore the external input while run enable is clear.
// - Level limit resets on period match or two clocks after input asserts.
// - Level limit restarts after period match or two clocks after input release.
// - Drive stays high through an external reset until count reaches pulse width.
// - Software one shot b01000 resets count and clears run enable at match.
// - Software one shot pauses on clear; new cycle only after match cleared it.
// - Edge one shot starts on edge after run enable; clears it at match.
// - Edge one shot resumes only on a fresh edge after run enable set.
// - Edge limit one shot: first edge starts, later edges reset the count.
// - Edge limit one shot clears run enable at match; edges need run enable.
// - Level reset edge one shot holds reset at level, starts on active transition.
// - Level reset edge one shot clears run enable at match; needs new edge.
// - Monostable starts on edge after run enable and stops at period match.
// - Monostable ignores edges while counting; match gives no cycle start.
// - Level limit one shot counts once run enable set and input leaves reset.
// - Level limit one shot clears run enable at match, then holds reset.
// - Edge limit one shot signals cycle start on start and each reset edge.
// - Software one shot pause keeps drive until count reaches pulse width.
// - Level reset edge one shot match gives no cycle start.
// - Clear run enable resets the mode state machine.
// - Monostable stops at zero after match, run enable kept.

package tmhl_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_PERIOD = 4'h4;
	localparam logic [3:0] OFS_COUNT  = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	localparam int CTRL_ON_BIT   = 0;
	localparam int CTRL_MODE_LSB = 8;
	localparam logic [4:0] MODE_RESET_VAL   = 5'h00;
	localparam logic [7:0] PERIOD_RESET_VAL = 8'hff;

	// ==========================================================
	// Mode codes
	localparam logic [4:0] MODE_LVL_HL_LO  = 5'h06;
	localparam logic [4:0] MODE_LVL_HL_HI  = 5'h07;
	localparam logic [4:0] MODE_SW_ONESHOT = 5'h08;
	localparam logic [4:0] MODE_EOS_RISE   = 5'h09;
	localparam logic [4:0] MODE_EOS_FALL   = 5'h0a;
	localparam logic [4:0] MODE_EOS_ANY    = 5'h0b;
	localparam logic [4:0] MODE_EHL_RISE   = 5'h0c;
	localparam logic [4:0] MODE_EHL_FALL   = 5'h0d;
	localparam logic [4:0] MODE_LRE_LO     = 5'h0e;
	localparam logic [4:0] MODE_LRE_HI     = 5'h0f;
	localparam logic [4:0] MODE_MONO_RISE  = 5'h11;
	localparam logic [4:0] MODE_MONO_FALL  = 5'h12;
	localparam logic [4:0] MODE_MONO_ANY   = 5'h13;
	localparam logic [4:0] MODE_LHO_LO     = 5'h16;
	localparam logic [4:0] MODE_LHO_HI     = 5'h17;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} tmhl_state_t;

	typedef struct packed {
		logic       cycle_start;
		logic [7:0] count_value;
	} tmhl_tb_t;

endpackage

// ==== src/tmhl_timer.sv ====
// Hardware-limit timer mode control with a Wishbone register slave.
// Assumes the external reset input is sampled here through a synchroniser
// and that the attached compare/PWM unit reads the time-base struct.
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module tmhl_timer #(
	parameter int CNT_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              ext_reset_input,
	output tmhl_pkg::tmhl_tb_t     count_value_inst
);

	// ==========================================================
	// Elaboration check
	if (CNT_W != 8) begin : g_bad_width
		$error("tmhl_timer: CNT_W must be 8");
	end

	// ==========================================================
	// Registers
	logic                  on_reg;
	logic [4:0]            mode_reg;
	logic [CNT_W-1:0]      period_value;
	logic [CNT_W-1:0]      cnt_reg;
	logic [CNT_W-1:0]      cnt_next;
	tmhl_pkg::tmhl_state_t st_reg;
	tmhl_pkg::tmhl_state_t st_next;
	logic                  start_reg;
	logic                  start_next;
	logic                  hw_clear;
	logic                  ers_s1_reg;
	logic                  ers_s2_reg;
	logic                  ers_s3_reg;
	logic                  ack_reg;
	logic [31:0]           rdat_reg;

	logic                  wb_req;
	logic                  wr_ctrl;
	logic                  wr_period;
	logic                  rise;
	logic                  fall;
	logic                  rst_lvl;
	logic                  match;

	// ==========================================================
	// Functions
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		// 01 rising, 10 falling, 11 either
		edge_hit = (sel[0] & r) | (sel[1] & f);
	endfunction

	function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
		inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction

	// ==========================================================
	// Wishbone slave
	// Ack one cycle after the request, dropped the next cycle
	assign wb_req    = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr_ctrl   = wb_req & wb_we_i & (wb_adr_i == tmhl_pkg::OFS_CTRL);
	assign wr_period = wb_req & wb_we_i & (wb_adr_i == tmhl_pkg::OFS_PERIOD) & wb_sel_i[0];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdat_reg <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			if (wb_adr_i == tmhl_pkg::OFS_CTRL) begin
				rdat_reg <= {19'h0, mode_reg, 7'h00, on_reg};
			end else if (wb_adr_i == tmhl_pkg::OFS_PERIOD) begin
				rdat_reg <= {24'h0, period_value};
			end else if (wb_adr_i == tmhl_pkg::OFS_COUNT) begin
				rdat_reg <= {24'h0, cnt_reg};
			end else if (wb_adr_i == tmhl_pkg::OFS_STATUS) begin
				rdat_reg <= {28'h0, st_reg == tmhl_pkg::ST_RUN, ers_s2_reg, start_reg, on_reg};
			end else begin
				// Unmapped addresses read as zero
				rdat_reg <= 32'h0000_0000;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// ==========================================================
	// Control registers
	// Software write beats a same-cycle hardware clear of run enable
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			on_reg <= 1'b0;
		end else if (wr_ctrl && wb_sel_i[0]) begin
			on_reg <= wb_dat_i[tmhl_pkg::CTRL_ON_BIT];
		end else if (hw_clear) begin
			on_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= tmhl_pkg::MODE_RESET_VAL;
		end else if (wr_ctrl && wb_sel_i[1]) begin
			mode_reg <= wb_dat_i[tmhl_pkg::CTRL_MODE_LSB +: 5];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			period_value <= tmhl_pkg::PERIOD_RESET_VAL;
		end else if (wr_period) begin
			period_value <= wb_dat_i[CNT_W-1:0];
		end
	end

	// ==========================================================
	// External input synchroniser
	// Stage one feeds only stage two; edges use stages two and three
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ers_s1_reg <= 1'b0;
			ers_s2_reg <= 1'b0;
			ers_s3_reg <= 1'b0;
		end else begin
			ers_s1_reg <= ext_reset_input;
			ers_s2_reg <= ers_s1_reg;
			ers_s3_reg <= ers_s2_reg;
		end
	end

	assign rise    = ers_s2_reg & ~ers_s3_reg;
	assign fall    = ~ers_s2_reg & ers_s3_reg;
	// Mode bit zero picks the reset level: clear means low resets
	assign rst_lvl = mode_reg[0] ? ers_s2_reg : ~ers_s2_reg;
	assign match   = (cnt_reg == period_value);

	// ==========================================================
	// Mode engine
	always_comb begin
		cnt_next   = cnt_reg;
		st_next    = st_reg;
		start_next = 1'b0;
		hw_clear   = 1'b0;
		if (!on_reg) begin
			// Count kept so a paused one shot can resume
			st_next = tmhl_pkg::ST_IDLE;
		end else begin
			case (mode_reg)
				tmhl_pkg::MODE_LVL_HL_LO, tmhl_pkg::MODE_LVL_HL_HI: begin
					if (rst_lvl) begin
						cnt_next = '0;
						st_next  = tmhl_pkg::ST_IDLE;
					end else if (st_reg == tmhl_pkg::ST_IDLE) begin
						st_next    = tmhl_pkg::ST_RUN;
						start_next = 1'b1;
					end else if (match) begin
						cnt_next   = '0;
						start_next = 1'b1;
					end else begin
						// Pulse width compare left to the PWM unit
						cnt_next = inc(cnt_reg);
					end
				end
				tmhl_pkg::MODE_SW_ONESHOT: begin
					if (st_reg == tmhl_pkg::ST_IDLE) begin
						st_next    = tmhl_pkg::ST_RUN;
						// Resume after a pause gives no new start
						start_next = (cnt_reg == '0);
					end else if (match) begin
						cnt_next = '0;
						hw_clear = 1'b1;
						st_next  = tmhl_pkg::ST_IDLE;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
				tmhl_pkg::MODE_EOS_RISE, tmhl_pkg::MODE_EOS_FALL,
				tmhl_pkg::MODE_EOS_ANY: begin
					if (st_reg == tmhl_pkg::ST_IDLE) begin
						if (edge_hit(mode_reg[1:0], rise, fall)) begin
							st_next    = tmhl_pkg::ST_RUN;
							start_next = 1'b1;
						end
					end else if (match) begin
						cnt_next = '0;
						hw_clear = 1'b1;
						st_next  = tmhl_pkg::ST_IDLE;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
				tmhl_pkg::MODE_EHL_RISE, tmhl_pkg::MODE_EHL_FALL: begin
					if (st_reg == tmhl_pkg::ST_IDLE) begin
						if (mode_reg[0] ? fall : rise) begin
							st_next    = tmhl_pkg::ST_RUN;
							start_next = 1'b1;
						end
					end else if (mode_reg[0] ? fall : rise) begin
						cnt_next   = '0;
						start_next = 1'b1;
					end else if (match) begin
						cnt_next = '0;
						hw_clear = 1'b1;
						st_next  = tmhl_pkg::ST_IDLE;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
				tmhl_pkg::MODE_LRE_LO, tmhl_pkg::MODE_LRE_HI: begin
					if (rst_lvl) begin
						cnt_next = '0;
						st_next  = tmhl_pkg::ST_IDLE;
					end else if (st_reg == tmhl_pkg::ST_IDLE) begin
						// Low reset starts on rise, high reset on fall
						if (mode_reg[0] ? fall : rise) begin
							st_next    = tmhl_pkg::ST_RUN;
							start_next = 1'b1;
						end
					end else if (match) begin
						cnt_next = '0;
						hw_clear = 1'b1;
						st_next  = tmhl_pkg::ST_IDLE;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
				tmhl_pkg::MODE_MONO_RISE, tmhl_pkg::MODE_MONO_FALL,
				tmhl_pkg::MODE_MONO_ANY: begin
					if (st_reg == tmhl_pkg::ST_IDLE) begin
						if (edge_hit(mode_reg[1:0], rise, fall)) begin
							st_next    = tmhl_pkg::ST_RUN;
							start_next = 1'b1;
						end
					end else if (match) begin
						// Run enable kept; the next edge rearms
						cnt_next = '0;
						st_next  = tmhl_pkg::ST_IDLE;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
				tmhl_pkg::MODE_LHO_LO, tmhl_pkg::MODE_LHO_HI: begin
					if (rst_lvl) begin
						cnt_next = '0;
						st_next  = tmhl_pkg::ST_IDLE;
					end else if (st_reg == tmhl_pkg::ST_IDLE) begin
						st_next    = tmhl_pkg::ST_RUN;
						start_next = 1'b1;
					end else if (match) begin
						cnt_next = '0;
						hw_clear = 1'b1;
						st_next  = tmhl_pkg::ST_IDLE;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
				default: begin
					// Unsupported codes behave as a free-running period timer
					if (st_reg == tmhl_pkg::ST_IDLE) begin
						st_next    = tmhl_pkg::ST_RUN;
						start_next = 1'b1;
					end else if (match) begin
						cnt_next   = '0;
						start_next = 1'b1;
					end else begin
						cnt_next = inc(cnt_reg);
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Counter, state and cycle start
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= tmhl_pkg::ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_reg <= 1'b0;
		end else begin
			start_reg <= start_next;
		end
	end

	assign count_value_inst = {start_reg, cnt_reg};

endmodule

`default_nettype wire

// ==== verif/test_timer_hw_limit_oneshot_modes.sv ====
// Self-checking bench for the hardware-limit timer mode control.
// Assumes the PWM model here and the checker bound to the design.
`timescale 1ns/10ps
`default_nettype none
module test_timer_hw_limit_oneshot_modes;
	localparam logic [4:0] MD [12] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h11,
		5'h12, 5'h13, 5'h0e, 5'h0f, 5'h16, 5'h17};
	localparam logic [11:0] IDLE = 12'ha52;
	localparam logic [11:0] STEP = 12'hf00;
	localparam logic [11:0] TWO  = 12'h018;
	localparam logic [11:0] KEEP = 12'h0e0;
	logic               sys_clk;
	logic               rst;
	logic               cyc;
	logic               we;
	logic [3:0]         adr;
	logic [3:0]         sel;
	logic [31:0]        dat;
	logic [31:0]        dat_o;
	logic               ack;
	logic               ers;
	logic               drive;
	logic [31:0]        q;
	logic [7:0]         c1;
	int                 fails;
	int                 tests_run;
	int                 starts;
	int                 s0;
	int                 cycles;
	tmhl_pkg::tmhl_tb_t tb;
	tmhl_timer #(.CNT_W(8)) uut (
		.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ext_reset_input(ers), .count_value_inst(tb)
	);
	tmhl_pwm_model pwm (.sys_clk(sys_clk), .rst(rst), .tbase(tb),
		.pulse_width_compare(8'h08), .drive(drive));
	// ==========
	// Tasks
	task automatic close_out();
		$display("Checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge sys_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// Ack is sampled at rising edges only; data taken at that same edge
		@(posedge sys_clk);
		while (ack !== 1'b1)
			@(posedge sys_clk);
		q = dat_o;
		cyc <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(nm, q, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic ex(input logic v, input int n);
		@(posedge sys_clk);
		ers <= v;
		tick(n);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Pulses are counted mid-cycle, clear of the launching edge
	always @(negedge sys_clk) begin
		cycles++;
		if (tb.cycle_start === 1'b1)
			starts++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	// ==========
	// Sequence
	initial begin
		{rst, cyc, we, adr, sel, dat, ers} = {1'b1, 43'h0};
		{fails, tests_run, starts, cycles} = {32'h0, 32'h0, 32'h0, 32'h0};
		tick(6);
		rst <= 1'b0;
		rd(4'h0, 32'h0, "ctrl");
		rd(4'h4, 32'hff, "period");
		bus(1'b1, 4'h8, 32'h55, 4'hf);
		rd(4'h8, 32'h0, "count");
		rd(4'h2, 32'h0, "unmapped");
		bus(1'b1, 4'h4, 32'h0a, 4'h1);
		rd(4'h4, 32'h0a, "period");
		s0 = starts;
		bus(1'b1, 4'h0, 32'h0801, 4'h3);
		bus(1'b1, 4'h0, 32'h0800, 4'h3);
		bus(1'b0, 4'h8, 32'h0, 4'hf);
		c1 = q[7:0];
		tick(4);
		rd(4'h8, {24'h0, c1}, "paused count");
		chk("drive", 32'(drive), 32'h1);
		bus(1'b1, 4'h0, 32'h0801, 4'h3);
		tick(30);
		chk("starts", 32'(starts - s0), 32'h1);
		chk("drive", 32'(drive), 32'h0);
		rd(4'h0, 32'h0800, "ctrl");
		for (int i = 0; i < 2; i++) begin
			ex(~i[0], 2);
			bus(1'b1, 4'h0, {19'h0, 4'h3, i[0], 8'h01}, 4'h3);
			ex(i[0], 8);
			chk("drive", 32'(drive), 32'h1);
			rd(4'h8, 32'h0, "held count");
			rd(4'hc, {28'h0, 1'b0, i[0], 2'b01}, "status");
			ex(~i[0], 20);
			// Disable while held, so the kept count is zero for the next mode
			ex(i[0], 4);
			bus(1'b1, 4'h0, {19'h0, 4'h3, i[0], 8'h00}, 4'h3);
		end
		for (int i = 0; i < 12; i++) begin
			s0 = starts;
			ex(IDLE[i], 4);
			bus(1'b1, 4'h0, {19'h0, MD[i], 8'h01}, 4'h3);
			tick(4);
			rd(4'h8, 32'h0, "waiting count");
			ex(~IDLE[i], 3);
			if (!STEP[i]) begin
				// Extra edges end before the match, so a monostable cannot rearm
				ex(IDLE[i], 2);
				ex(~IDLE[i], 2);
				ex(IDLE[i], 2);
			end
			tick(30);
			chk("starts", 32'(starts - s0), TWO[i] ? 32'h2 : 32'h1);
			rd(4'h0, {19'h0, MD[i], 7'h0, KEEP[i]}, "ctrl");
			rd(4'h8, 32'h0, "final count");
			bus(1'b1, 4'h0, {19'h0, MD[i], 8'h00}, 4'h3);
		end
		close_out();
	end
endmodule
`default_nettype wire

// ==== verif/tmhl_pwm_model.sv ====
// Model of the compare/PWM unit paced by the timer's time base.
// Assumes the struct output of the timer and a fixed pulse width.
`timescale 1ns/10ps
`default_nettype none
module tmhl_pwm_model (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire tmhl_pkg::tmhl_tb_t tbase,
	input  wire logic [7:0]         pulse_width_compare,
	output logic                    drive
);
	// Drive falls only at the width match, so pauses stretch it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			drive <= 1'b0;
		else if (tbase.cycle_start)
			drive <= 1'b1;
		else if (tbase.count_value == pulse_width_compare)
			drive <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== verif/tmhl_timer_properties.sv ====
// Checker for the timer's bus and time-base outputs.
// Assumes a bind to tmhl_timer; mode, period and run enable are shadowed from writes.
`timescale 1ns/10ps
`default_nettype none
module tmhl_timer_properties #(
	parameter int CNT_W = 8
) (
	input wire logic               sys_clk,
	input wire logic               rst,
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [3:0]         wb_adr_i,
	input wire logic [3:0]         wb_sel_i,
	input wire logic [31:0]        wb_dat_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	input wire logic               ext_reset_input,
	input wire tmhl_pkg::tmhl_tb_t count_value_inst
);
	// ==========
	// Shadows
	logic [4:0] mode_sh;
	logic [7:0] per_sh;
	logic       on_sh;
	logic       wr_ok;
	logic       lvl;
	logic       lrst;
	logic       mono;
	logic       stp;
	logic [7:0] cnt;
	assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign stp = count_value_inst.cycle_start;
	assign cnt = count_value_inst.count_value;
	assign lvl = on_sh && mode_sh[4:1] == 4'h3;
	assign lrst = mode_sh[4:1] == 4'h7 || mode_sh[4:1] == 4'hb;
	assign mono = mode_sh[4:2] == 3'h4 && mode_sh[1:0] != 2'h0;
	// Hardware clears of run enable are not seen; used only where harmless
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_sh <= 5'h00;
			on_sh <= 1'b0;
			per_sh <= 8'hff;
		end else if (wr_ok && wb_adr_i == tmhl_pkg::OFS_CTRL) begin
			if (wb_sel_i[0])
				on_sh <= wb_dat_i[0];
			if (wb_sel_i[1])
				mode_sh <= wb_dat_i[12:8];
		end else if (wr_ok && wb_adr_i == tmhl_pkg::OFS_PERIOD && wb_sel_i[0]) begin
			per_sh <= wb_dat_i[7:0];
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_held;
		(lvl && ext_reset_input == mode_sh[0]) [*5];
	endsequence
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_start_pulse: assert property (stp |=> !stp)
		else $error("start too long");
	a_level_hold: assert property (s_held |-> cnt == 8'h00)
		else $error("count not held");
	a_level_restart: assert property (s_held ##1 (lvl && ext_reset_input != mode_sh[0]) |-> ##[1:5] stp)
		else $error("no restart");
	a_level_ignore: assert property (mode_sh[4:1] == 4'h3 && !on_sh && !$past(on_sh) |-> $stable(cnt) && !stp)
		else $error("input not ignored");
	a_match_clear: assert property (on_sh && cnt == per_sh |=> cnt == 8'h00)
		else $error("no clear at match");
	a_mono_quiet: assert property (mono && stp |-> $past(cnt) == 8'h00)
		else $error("monostable restarted");
	a_lreset_hold: assert property ((lrst && ext_reset_input == mode_sh[0]) [*5] |-> cnt == 8'h00)
		else $error("count not held");
endmodule
bind tmhl_timer tmhl_timer_properties #(.CNT_W(CNT_W)) u_props (
	.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_input(ext_reset_input),
	.count_value_inst(count_value_inst)
);
`default_nettype wire
